// ==== pkg/lbhg_defs.svh ====
// Constants for the local bus hold and grant block
`ifndef LBHG_DEFS_SVH
`define LBHG_DEFS_SVH

// Synchronised pin vector width and bit positions
`define LBHG_NPIN 12
`define LBHG_P_HOLD 0
`define LBHG_P_NMI 1
`define LBHG_P_SUSPEND_REQUEST_IN_N 2
`define LBHG_P_INVAL_N 3
`define LBHG_P_DONE_N 4
`define LBHG_P_NA_N 5
`define LBHG_P_BUS16_SIZE_N_N 6
`define LBHG_P_KEN_N 7
`define LBHG_P_IRQ 8
`define LBHG_P_COP_LO 9
`define LBHG_P_COP_HI 11

// Reset values of the pin vector (inactive levels)
`define LBHG_PIN_RST 12'hcfc
// Coprocessor inputs held inactive: request low, busy and error high
`define LBHG_COP_IDLE 3'h6
// Gated input word while ignored: coproc, irq low, three strobes high
`define LBHG_GATE_IDLE {`LBHG_COP_IDLE, 4'h7}
// Bus output enable while driving
`define LBHG_OE_ON 1'b1

`endif

// ==== pkg/lbhg_pkg.sv ====
// Types for the local bus hold and grant block
package lbhg_pkg;
   typedef enum logic [1:0] {
      LBHG_IDLE = 2'b00,
      LBHG_CYCLE = 2'b01,
      LBHG_HOLD = 2'b10
   } lbhg_state_t;
endpackage

// ==== pkg/lbhg_sync_if.sv ====
// Carrier between the pin synchroniser and the arbiter
`timescale 1ns/1ps
`include "lbhg_defs.svh"
interface lbhg_sync_if;
   logic [`LBHG_NPIN-1:0] raw;
   logic [`LBHG_NPIN-1:0] synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface

// ==== rtl/lbhg_sync.sv ====
// Two-stage synchroniser for the asynchronous input pins
`timescale 1ns/1ps
`include "lbhg_defs.svh"
module lbhg_sync (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Pins in, synchronised out
   lbhg_sync_if.sync pins
);
   logic [`LBHG_NPIN-1:0] meta_r, meta_nxt;
   logic [`LBHG_NPIN-1:0] stab_r, stab_nxt;

   always_comb begin
      meta_nxt = meta_r;
      stab_nxt = stab_r;
      if (ce) begin
         meta_nxt = pins.raw;
         stab_nxt = meta_r;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_r <= `LBHG_PIN_RST;
         stab_r <= `LBHG_PIN_RST;
      end else begin
         meta_r <= meta_nxt;
         stab_r <= stab_nxt;
      end
   end

   assign pins.synced = stab_r;
endmodule // lbhg_sync

// ==== rtl/lbhg_arbiter.sv ====
// Local bus hold and grant arbiter
`timescale 1ns/1ps
`include "lbhg_defs.svh"

// What this block does
// - Finish current or locked cycles before granting
// - Float the bus pins while grant high
// - Keep bus granted while request stays high
// - Drive bus again as grant falls
// - Reset beats request; go idle
// - Grant still works during suspend
// - Grant and suspend acknowledge stay driven
// - Core runs on cache during hold
// - Store one interrupt edge during hold
// - Cache invalidate still honoured during hold
// - Suspend during hold depends on pipeline
// - Reset aborts cycle and ends hold
module lbhg_arbiter (
   // Clock, reset, enable
   clk,
   reset,
   ce,
   // Pins from the system
   hold_request,
   nonmaskable_irq,
   suspend_request_in,
   cache_invalidate_in,
   cycle_done_n,
   next_addr_req_n,
   bus16_size_n,
   cacheable_n,
   maskable_irq,
   coproc_in,
   // Core side
   core_cycle_req,
   core_locked,
   core_pipe_empty,
   core_needs_bus,
   // Pins to the system
   bus_grant_ack,
   bus_out_oe,
   suspend_ack_out,
   suspend_ack_oe,
   // Results to the core
   cycle_start,
   cycle_end,
   core_stall,
   nmi_take,
   cache_inval,
   next_addr_req_q_n,
   bus16_size_q_n,
   cacheable_q_n,
   maskable_irq_q,
   coproc_q
);
   input wire logic clk;
   input wire logic reset;
   input wire logic ce;
   input wire logic hold_request;
   input wire logic nonmaskable_irq;
   input wire logic suspend_request_in;
   input wire logic cache_invalidate_in;
   input wire logic cycle_done_n;
   input wire logic next_addr_req_n;
   input wire logic bus16_size_n;
   input wire logic cacheable_n;
   input wire logic maskable_irq;
   input wire logic [2:0] coproc_in;
   input wire logic core_cycle_req;
   input wire logic core_locked;
   input wire logic core_pipe_empty;
   input wire logic core_needs_bus;
   output logic bus_grant_ack;
   output logic bus_out_oe;
   output logic suspend_ack_out;
   output logic suspend_ack_oe;
   output logic cycle_start;
   output logic cycle_end;
   output logic core_stall;
   output logic nmi_take;
   output logic cache_inval;
   output logic next_addr_req_q_n;
   output logic bus16_size_q_n;
   output logic cacheable_q_n;
   output logic maskable_irq_q;
   output logic [2:0] coproc_q;

   // ==========================================================
   // Input synchronisers
   lbhg_sync_if pins ();
   logic [`LBHG_NPIN-1:0] s;

   assign pins.raw = {coproc_in, maskable_irq, cacheable_n, bus16_size_n,
      next_addr_req_n, cycle_done_n, cache_invalidate_in,
      suspend_request_in, nonmaskable_irq, hold_request};
   assign s = pins.synced;

   lbhg_sync u_sync (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .pins(pins)
   );

   logic hold_s, nmi_s, suspend_request_in_s, inval_s, done_s;
   assign hold_s = s[`LBHG_P_HOLD];
   assign nmi_s = s[`LBHG_P_NMI];
   assign suspend_request_in_s = ~s[`LBHG_P_SUSPEND_REQUEST_IN_N];
   assign inval_s = ~s[`LBHG_P_INVAL_N];
   assign done_s = ~s[`LBHG_P_DONE_N];

   // ==========================================================
   // Bus ownership state machine
   lbhg_pkg::lbhg_state_t st_r, st_nxt;
   logic grant_r, grant_nxt, oe_r, oe_nxt;
   logic start_r, start_nxt, end_r, end_nxt;
   logic suspend_request_in_r, suspend_request_in_nxt;

   always_comb begin
      st_nxt = st_r;
      start_nxt = 1'b0;
      end_nxt = 1'b0;
      suspend_request_in_nxt = suspend_request_in_r;
      if (ce) begin
         case (st_r)
            lbhg_pkg::LBHG_IDLE: begin
               if (hold_s) begin
                  st_nxt = lbhg_pkg::LBHG_HOLD;
               end else if (core_cycle_req && !suspend_request_in_r) begin
                  st_nxt = lbhg_pkg::LBHG_CYCLE;
                  start_nxt = 1'b1;
               end
            end
            lbhg_pkg::LBHG_CYCLE: begin
               // Locked sequences keep the bus across cycles
               if (done_s) begin
                  end_nxt = 1'b1;
                  if (core_locked && core_cycle_req) begin
                     start_nxt = 1'b1;
                  end else if (hold_s) begin
                     st_nxt = lbhg_pkg::LBHG_HOLD;
                  end else begin
                     st_nxt = lbhg_pkg::LBHG_IDLE;
                  end
               end
            end
            lbhg_pkg::LBHG_HOLD: begin
               if (!hold_s) begin
                  st_nxt = lbhg_pkg::LBHG_IDLE;
               end
            end
            default: st_nxt = lbhg_pkg::LBHG_IDLE;
         endcase
         // Suspend only from a quiet point; pipeline decides in hold
         if (!suspend_request_in_s) begin
            suspend_request_in_nxt = 1'b0;
         end else if (core_pipe_empty && st_r != lbhg_pkg::LBHG_CYCLE) begin
            suspend_request_in_nxt = 1'b1;
         end
      end
      grant_nxt = (st_nxt == lbhg_pkg::LBHG_HOLD);
      oe_nxt = ~grant_nxt;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= lbhg_pkg::LBHG_IDLE;
         grant_r <= 1'b0;
         oe_r <= `LBHG_OE_ON;
         start_r <= 1'b0;
         end_r <= 1'b0;
         suspend_request_in_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         grant_r <= grant_nxt;
         oe_r <= oe_nxt;
         start_r <= start_nxt;
         end_r <= end_nxt;
         suspend_request_in_r <= suspend_request_in_nxt;
      end
   end

   // ==========================================================
   // Interrupt edge store, invalidate, input gating
   logic nmi_d_r, nmi_d_nxt, nmi_pend_r, nmi_pend_nxt;
   logic take_r, take_nxt, inval_r, inval_nxt;
   logic stall_r, stall_nxt;
   logic [6:0] gate_r, gate_nxt;
   logic nmi_edge;

   // Hold decisions follow the next state so gating starts with grant
   assign nmi_edge = nmi_s & ~nmi_d_r;

   always_comb begin
      nmi_d_nxt = nmi_d_r;
      nmi_pend_nxt = nmi_pend_r;
      take_nxt = 1'b0;
      inval_nxt = inval_r;
      stall_nxt = stall_r;
      gate_nxt = gate_r;
      if (ce) begin
         nmi_d_nxt = nmi_s;
         if (grant_nxt) begin
            if (nmi_edge) begin
               nmi_pend_nxt = 1'b1;
            end
         end else if (nmi_pend_r || nmi_edge) begin
            take_nxt = 1'b1;
            nmi_pend_nxt = 1'b0;
         end
         inval_nxt = inval_s;
         stall_nxt = grant_nxt & core_needs_bus;
         if (grant_nxt) begin
            gate_nxt = `LBHG_GATE_IDLE;
         end else begin
            gate_nxt = s[`LBHG_P_COP_HI:`LBHG_P_NA_N];
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         nmi_d_r <= 1'b0;
         nmi_pend_r <= 1'b0;
         take_r <= 1'b0;
         inval_r <= 1'b0;
         stall_r <= 1'b0;
         gate_r <= `LBHG_GATE_IDLE;
      end else begin
         nmi_d_r <= nmi_d_nxt;
         nmi_pend_r <= nmi_pend_nxt;
         take_r <= take_nxt;
         inval_r <= inval_nxt;
         stall_r <= stall_nxt;
         gate_r <= gate_nxt;
      end
   end

   // ==========================================================
   // Outputs from flip-flops, suspend_ack_out through an inverter
   logic oe_on_r;
   assign bus_grant_ack = grant_r;
   assign bus_out_oe = oe_r;
   assign suspend_ack_out = ~suspend_request_in_r;
   assign suspend_ack_oe = oe_on_r;
   assign cycle_start = start_r;
   assign cycle_end = end_r;
   assign core_stall = stall_r;
   assign nmi_take = take_r;
   assign cache_inval = inval_r;
   assign next_addr_req_q_n = gate_r[0];
   assign bus16_size_q_n = gate_r[1];
   assign cacheable_q_n = gate_r[2];
   assign maskable_irq_q = gate_r[3];
   assign coproc_q = gate_r[6:4];

   // Suspend acknowledge is never floated
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         oe_on_r <= `LBHG_OE_ON;
      end else begin
         oe_on_r <= `LBHG_OE_ON;
      end
   end
endmodule // lbhg_arbiter

// ==== bench/lbhg_master.sv ====
// Model of the bus master that asks for the local bus
`timescale 1ns/1ps
module lbhg_master (
   // Clock and command
   input wire logic clk,
   input wire logic want,
   input wire logic [2:0] lag,
   // Request pin
   output logic hold_request
);
   logic [2:0] cnt_r = 3'h0;
   initial hold_request = 1'b0;
   // Request held as a level for the whole tenure, after a chosen lag
   always @(negedge clk) begin
      if (!want) begin
         hold_request <= 1'b0;
         cnt_r <= 3'h0;
      end else if (cnt_r >= lag) begin
         hold_request <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
endmodule // lbhg_master

// ==== bench/lbhg_arbiter_sva.sv ====
// Port assertions for the hold and grant arbiter
`timescale 1ns/1ps
module lbhg_arbiter_sva (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Watched pins
   input wire logic cache_invalidate_in,
   input wire logic core_needs_bus,
   input wire logic core_stall,
   input wire logic cycle_end,
   input wire logic hold_request,
   input wire logic bus_grant_ack,
   input wire logic bus_out_oe,
   input wire logic cycle_start,
   input wire logic nmi_take,
   input wire logic cache_inval,
   input wire logic next_addr_req_q_n,
   input wire logic bus16_size_q_n,
   input wire logic cacheable_q_n,
   input wire logic maskable_irq_q,
   input wire logic [2:0] coproc_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Open bus cycle, from its start pulse to its end pulse
   logic cyc_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cyc_r <= 1'b0;
      end else if (cycle_start) begin
         cyc_r <= 1'b1;
      end else if (cycle_end) begin
         cyc_r <= 1'b0;
      end
   end
   property p_float;
      bus_grant_ack |-> !bus_out_oe;
   endproperty
   a_float: assert property (p_float) else $error("bus driven in hold");
   property p_regain;
      $fell(bus_grant_ack) |-> bus_out_oe;
   endproperty
   a_regain: assert property (p_regain) else $error("bus not retaken");
   property p_keep;
      hold_request [*4] ##0 bus_grant_ack |=> bus_grant_ack;
   endproperty
   a_keep: assert property (p_keep) else $error("grant dropped");
   property p_rst;
      $fell(reset) |-> !bus_grant_ack [*3];
   endproperty
   a_rst: assert property (p_rst) else $error("grant from reset");
   property p_nmi;
      nmi_take |-> !bus_grant_ack ##1 !nmi_take;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi pulse wrong");
   property p_gate;
      bus_grant_ack |-> maskable_irq_q == 1'b0 && coproc_q == 3'h6 &&
         next_addr_req_q_n && bus16_size_q_n && cacheable_q_n;
   endproperty
   a_gate: assert property (p_gate) else $error("input not ignored");
   property p_cyc;
      $rose(bus_grant_ack) |-> !cyc_r || (cycle_end && !cycle_start);
   endproperty
   a_cyc: assert property (p_cyc) else $error("grant inside cycle");
   property p_inval;
      (!cache_invalidate_in) [*5] |-> cache_inval;
   endproperty
   a_inval: assert property (p_inval) else $error("invalidate lost");
   property p_stall;
      $past(ce) |-> core_stall == (bus_grant_ack && $past(core_needs_bus));
   endproperty
   a_stall: assert property (p_stall) else $error("stall wrong");
   c_grant: cover property ($rose(bus_grant_ack));
   c_nmi: cover property (nmi_take);
   c_inval: cover property (bus_grant_ack && cache_inval);
endmodule // lbhg_arbiter_sva
bind lbhg_arbiter lbhg_arbiter_sva lbhg_arbiter_sva_inst (.*);

// ==== bench/lbhg_arbiter_tb.sv ====
// Self-checking bench for the hold and grant arbiter
`timescale 1ns/1ps
module lbhg_arbiter_tb;
   logic clk = 1'b0, reset = 1'b1, ce = 1'b1, want = 1'b1;
   logic nonmaskable_irq = 1'b0, suspend_request_in = 1'b1;
   logic cache_invalidate_in = 1'b1, cycle_done_n = 1'b1;
   logic next_addr_req_n, bus16_size_n, cacheable_n, maskable_irq;
   logic core_cycle_req = 1'b0, core_locked = 1'b0, core_needs_bus;
   logic core_pipe_empty = 1'b1, hold_request, bus_grant_ack, bus_out_oe;
   logic suspend_ack_out, suspend_ack_oe, cycle_start, cycle_end;
   logic core_stall, nmi_take, cache_inval, next_addr_req_q_n;
   logic bus16_size_q_n, cacheable_q_n, maskable_irq_q;
   logic [2:0] coproc_in, coproc_q, lag = 3'h0;
   logic [7:0] nz = 8'hf0;
   logic [31:0] rs = 32'h00000eea;
   int n_fail = 0, n_compared = 0, ntk = 0;
   assign {next_addr_req_n, bus16_size_n, cacheable_n, maskable_irq,
      coproc_in, core_needs_bus} = nz;
   lbhg_arbiter lbhg_arbiter_inst (.*);
   lbhg_master lbhg_master_inst (.clk(clk), .want(want), .lag(lag),
      .hold_request(hold_request));
   initial forever #4 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // Gated inputs at their inactive levels
   function automatic logic [6:0] idle_vec();
      return {3'h6, 1'b0, 3'h7};
   endfunction
   task automatic conclude();
      $display("Compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [6:0] e,
      input logic [6:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wt(input logic v);
      for (int i = 0; i < 40 && bus_grant_ack !== v; i++) @(negedge clk);
      if (bus_grant_ack !== v) begin
         n_fail++;
         $display("CHECK FAILED grant wait expected %b seen %b", v,
            bus_grant_ack);
         conclude();
      end
   endtask
   always @(negedge clk) begin
      rs <= xs(rs);
      nz <= rs[7:0];
   end
   always @(posedge clk) if (nmi_take === 1'b1) ntk++;
   initial begin
      repeat (3) @(negedge clk);
      chk("grant in reset", 7'h0, {6'h0, bus_grant_ack});
      reset = 1'b0;
      repeat (2) @(negedge clk);
      chk("grant after reset", 7'h0, {6'h0, bus_grant_ack});
      wt(1'b1);
      chk("enable in hold", 7'h0, {6'h0, bus_out_oe});
      chk("gated", idle_vec(), {coproc_q, maskable_irq_q, cacheable_q_n,
         bus16_size_q_n, next_addr_req_q_n});
      nonmaskable_irq = 1'b1;
      cache_invalidate_in = 1'b0;
      repeat (5) @(negedge clk);
      nonmaskable_irq = 1'b0;
      repeat (5) @(negedge clk);
      nonmaskable_irq = 1'b1;
      repeat (8) @(negedge clk);
      chk("grant held", 7'h1, {6'h0, bus_grant_ack});
      chk("invalidate", 7'h1, {6'h0, cache_inval});
      chk("nmi in hold", 7'h0, ntk[6:0]);
      ce = 1'b0;
      want = 1'b0;
      cache_invalidate_in = 1'b1;
      repeat (8) @(negedge clk);
      chk("grant frozen", 7'h1, {6'h0, bus_grant_ack});
      ce = 1'b1;
      wt(1'b0);
      chk("enable after hold", 7'h1, {6'h0, bus_out_oe});
      repeat (4) @(negedge clk);
      chk("nmi taken once", 7'h1, ntk[6:0]);
      core_cycle_req = 1'b1;
      core_locked = 1'b1;
      lag = 3'h5;
      repeat (2) @(negedge clk);
      want = 1'b1;
      repeat (12) @(negedge clk);
      cycle_done_n = 1'b0;
      @(negedge clk);
      cycle_done_n = 1'b1;
      repeat (10) @(negedge clk);
      chk("grant in locked run", 7'h0, {6'h0, bus_grant_ack});
      core_cycle_req = 1'b0;
      cycle_done_n = 1'b0;
      wt(1'b1);
      want = 1'b0;
      wt(1'b0);
      cycle_done_n = 1'b1;
      suspend_request_in = 1'b0;
      repeat (8) @(negedge clk);
      chk("suspend ack", 7'h0, {6'h0, suspend_ack_out});
      want = 1'b1;
      wt(1'b1);
      chk("ack driven", 7'h1, {6'h0, suspend_ack_oe});
      reset = 1'b1;
      #1 chk("grant at reset", 7'h0, {6'h0, bus_grant_ack});
      want = 1'b0;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      chk("grant after abort", 7'h0, {6'h0, bus_grant_ack});
      conclude();
   end
endmodule // lbhg_arbiter_tb
